// ===== include/cma_pkg.sv
// Constants, types and summary for the memory addressing block
// Summary of operation
// - Return stack holds 16 entries of 15 bits, apart from data memory.
// - Stack overflow or underflow sets its flag; optional reset request follows.
// - Interrupt entry saves W, STATUS, BSR, program counter latch high and both pointers in shadows; interrupt return restores them.
// - Two 16-bit indirect pointers reach all file registers and program memory.
// - Indirect data port reads of program memory take one extra cycle; writes take none.
// - Program counter is 15 bits over a 32K word space of 14 bits.
// - Program addresses past implemented memory wrap into the implemented range.
// - Execution starts at 0000h after reset; interrupts vector to 0004h.
// - Implemented program memory is 1024 words, last address 03FFh.
// - Addresses 0380h to 03FFh form the high-endurance region, low byte only.
// - Pointer high byte bit 7 set sends indirect reads to program memory.
// - Indirect read of program memory loads only the low 8 bits.
// - Indirect writes aimed at program memory change nothing.
// - Data memory has 32 banks of 128 bytes.
// - A bank holds 12 core, 20 special, up to 80 general, 16 shared bytes.
// - Direct accesses use the bank held in the bank select register.
// - Reads of unimplemented data memory return zero.
// - Data address is 12 bits; bank bits above, offset bits below.
// - Linear view of general RAM through pointers spans banks contiguously.
// - Core offers 49 instructions with direct, indirect, relative addressing.
// - Core registers occupy the first 12 locations of every bank.
package cma_pkg;
  localparam int PC_W = 15;
  localparam int STACK_DEPTH = 16;
  localparam int PROG_WORDS = 1024;
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] INT_VEC = 15'h0004;
  localparam logic [14:0] HE_LO = 15'h0380;
  localparam logic [14:0] HE_HI = 15'h03FF;
  localparam int BANK_BYTES = 128;
  localparam int NUM_BANKS = 32;
  localparam logic [6:0] CORE_END = 7'h0C;
  localparam logic [6:0] SFR_END = 7'h20;
  localparam logic [6:0] GPR_END = 7'h70;
  localparam logic [6:0] ADDR_PROBE = 7'h00;
  // Core register offsets
  localparam logic [6:0] OFS_IND0 = 7'h00;
  localparam logic [6:0] OFS_IND1 = 7'h01;
  localparam logic [6:0] OFS_PCL = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_P0L = 7'h04;
  localparam logic [6:0] OFS_P0H = 7'h05;
  localparam logic [6:0] OFS_P1L = 7'h06;
  localparam logic [6:0] OFS_P1H = 7'h07;
  localparam logic [6:0] OFS_BSR = 7'h08;
  localparam logic [6:0] OFS_WREG = 7'h09;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_LATCH_HIGH = 7'h0A;
  localparam logic [6:0] OFS_INTCON = 7'h0B;
  localparam int PTR_PROG_BIT = 15;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam int GPR_PER_BANK = 80;
  localparam int INSTR_COUNT = 49;
  typedef enum logic [1:0] {
    CMA_IDLE = 2'b00,
    CMA_PWAIT = 2'b01
  } cma_state_t;
endpackage : cma_pkg

// ===== rtl/cma_stack.sv
// Hardware return-address stack with overflow and underflow detection
module cma_stack #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Push and pop
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top_data,
  // Error pulses
  output logic overflow,
  output logic underflow
);
  localparam int PW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("bad depth");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW:0] count_reg;
  logic [PW-1:0] sp_reg;
  wire full = count_reg == (PW + 1)'(DEPTH);
  wire empty = count_reg == '0;
  wire [PW-1:0] rd_idx = sp_reg - PW'(1);
  assign top_data = mem_reg[rd_idx];
  assign overflow = push && full;
  assign underflow = pop && !push && empty;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      sp_reg <= '0;
    end else if (push && !full) begin
      sp_reg <= sp_reg + PW'(1);
      count_reg <= count_reg + (PW + 1)'(1);
    end else if (pop && !push && !empty) begin
      sp_reg <= rd_idx;
      count_reg <= count_reg - (PW + 1)'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (push && !full) begin
      mem_reg[sp_reg] <= push_data;
    end
  end
endmodule : cma_stack

// ===== rtl/cma_core.sv
// Program counter, return stack, shadows, pointers and data decode
module cma_core #(
  parameter int PROG_WORDS = 1024
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Sequencing from the instruction decoder
  input wire logic step,
  input wire logic jump,
  input wire logic [14:0] jump_addr,
  input wire logic call,
  input wire logic ret,
  input wire logic irq_take,
  input wire logic retfie,
  input wire logic stack_rst_en,
  // Working register result and status from the datapath
  input wire logic [7:0] wreg_in,
  input wire logic [4:0] status_in,
  // Direct file access
  input wire logic [6:0] dir_ofs,
  input wire logic dir_wr,
  input wire logic dir_rd,
  input wire logic [7:0] dir_wdata,
  // Indirect port access
  input wire logic ind_sel,
  input wire logic ind_rd,
  input wire logic ind_wr,
  input wire logic [7:0] ind_wdata,
  // Program memory word returned for fetch or table read
  input wire logic [13:0] prog_rdata,
  // Data RAM answer
  input wire logic [7:0] ram_rdata,
  // Program memory address
  output logic [14:0] prog_addr,
  output logic [14:0] pc_out,
  // Data RAM request
  output logic [11:0] ram_addr,
  output logic ram_wr,
  output logic ram_rd,
  output logic [7:0] ram_wdata,
  // Read data, stall and status
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic stall,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  output logic soft_reset,
  output logic high_endurance,
  output logic [4:0] bank_select_register,
  output logic [7:0] wreg_out
);
  localparam int AW = $clog2(PROG_WORDS);
  initial begin
    if (PROG_WORDS < 8 || PROG_WORDS > 32768 ||
        (PROG_WORDS & (PROG_WORDS - 1)) != 0) $error("bad program size");
  end
  // ****************
  // Program counter
  // ****************
  logic [14:0] pc_reg;
  logic [14:0] pc_next;
  logic [14:0] stk_top;
  logic stk_ovf;
  logic stk_unf;
  cma_stack #(
    .DEPTH(cma_pkg::STACK_DEPTH),
    .WIDTH(cma_pkg::PC_W)
  ) u_stack (
    .ref_clk(ref_clk),
    .rst(rst),
    .push((call || irq_take) && !stall),
    .pop((ret || retfie) && !stall),
    .push_data(irq_take ? pc_reg : pc_reg + 15'h0001),
    .top_data(stk_top),
    .overflow(stk_ovf),
    .underflow(stk_unf)
  );
  // Wrap into implemented words
  wire [14:0] pc_wrap = {{(15 - AW){1'b0}}, pc_next[AW-1:0]};
  always_comb begin
    pc_next = pc_reg;
    if (irq_take) begin
      pc_next = cma_pkg::INT_VEC;
    end else if (call || jump) begin
      pc_next = jump_addr;
    end else if (ret || retfie) begin
      pc_next = stk_top;
    end else if (step) begin
      pc_next = pc_reg + 15'h0001;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_reg <= cma_pkg::RESET_VEC;
    end else if (!stall) begin
      pc_reg <= pc_wrap;
    end
  end
  // ****************
  // Stack errors
  // ****************
  logic ovf_reg;
  logic unf_reg;
  logic srst_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_reg || (stk_ovf && !stall);
      unf_reg <= unf_reg || (stk_unf && !stall);
      srst_reg <= stack_rst_en && ((stk_ovf || stk_unf) && !stall);
    end
  end
  // ****************
  // Core registers
  // ****************
  logic [15:0] ptr_reg [2];
  logic [4:0] bsr_reg;
  logic [7:0] w_reg;
  logic [6:0] program_counter_latch_high_reg;
  logic [4:0] status_reg;
  logic [7:0] sh_w;
  logic [4:0] sh_bsr;
  logic [6:0] sh_program_counter_latch_high;
  logic [4:0] sh_status;
  logic [15:0] sh_ptr [2];
  wire dw = dir_wr && !stall;
  logic pend_reg;
  logic pend_q;
  logic [7:0] prog_byte_reg;
  wire [15:0] ptr = ptr_reg[ind_sel];
  wire prog_sel = ptr[cma_pkg::PTR_PROG_BIT];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_reg[0] <= 16'h0000;
      ptr_reg[1] <= 16'h0000;
      bsr_reg <= 5'h00;
      w_reg <= 8'h00;
      program_counter_latch_high_reg <= 7'h00;
      status_reg <= 5'h00;
      sh_ptr[0] <= 16'h0000;
      sh_ptr[1] <= 16'h0000;
      sh_w <= 8'h00;
      sh_bsr <= 5'h00;
      sh_program_counter_latch_high <= 7'h00;
      sh_status <= 5'h00;
    end else if (irq_take && !stall) begin
      sh_w <= w_reg;
      sh_bsr <= bsr_reg;
      sh_program_counter_latch_high <= program_counter_latch_high_reg;
      sh_status <= status_reg;
      sh_ptr[0] <= ptr_reg[0];
      sh_ptr[1] <= ptr_reg[1];
    end else if (retfie && !stall) begin
      w_reg <= sh_w;
      bsr_reg <= sh_bsr;
      program_counter_latch_high_reg <= sh_program_counter_latch_high;
      status_reg <= sh_status;
      ptr_reg[0] <= sh_ptr[0];
      ptr_reg[1] <= sh_ptr[1];
    end else begin
      w_reg <= wreg_in;
      status_reg <= status_in;
      if (ind_rd && prog_sel && pend_reg) begin
        w_reg <= prog_rdata[7:0];
      end
      if (dw) begin
        case (dir_ofs)
          cma_pkg::OFS_P0L: ptr_reg[0][7:0] <= dir_wdata;
          cma_pkg::OFS_P0H: ptr_reg[0][15:8] <= dir_wdata;
          cma_pkg::OFS_P1L: ptr_reg[1][7:0] <= dir_wdata;
          cma_pkg::OFS_P1H: ptr_reg[1][15:8] <= dir_wdata;
          cma_pkg::OFS_BSR: bsr_reg <= dir_wdata[4:0];
          cma_pkg::OFS_WREG: w_reg <= dir_wdata;
          cma_pkg::OFS_PROGRAM_COUNTER_LATCH_HIGH: program_counter_latch_high_reg <= dir_wdata[6:0];
          default: begin
          end
        endcase
      end
    end
  end
  // ****************
  // Indirect decode
  // ****************
  wire [14:0] ptr_pa = ptr[14:0];
  wire [14:0] ptr_pa_w = {{(15 - AW){1'b0}}, ptr_pa[AW-1:0]};
  // Linear GENERAL_PURPOSE_RAM: 80 bytes per bank from offset 20h
  wire [12:0] lin_ofs = ptr[12:0] - 13'h0000;
  wire [12:0] lin_bank = lin_ofs / 13'(cma_pkg::GPR_PER_BANK);
  wire [12:0] lin_in = lin_ofs % 13'(cma_pkg::GPR_PER_BANK);
  wire is_lin = ptr[14:13] == 2'b01;
  wire [11:0] lin_addr = {lin_bank[4:0], 7'(lin_in[6:0] + 7'h20)};
  wire [11:0] ind_daddr = is_lin ? lin_addr : ptr[11:0];
  wire [11:0] dir_daddr = {bsr_reg, dir_ofs};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= ind_rd && prog_sel && !pend_reg;
    end
  end
  assign stall = ind_rd && prog_sel && !pend_reg;
  // ****************
  // Data memory map
  // ****************
  wire [11:0] cur_addr = (ind_rd || ind_wr) ? ind_daddr : dir_daddr;
  wire [6:0] cur_ofs = cur_addr[6:0];
  wire is_core = cur_ofs < cma_pkg::CORE_END;
  wire is_sfr = !is_core && cur_ofs < cma_pkg::SFR_END;
  wire is_gpr = !is_core && !is_sfr && cur_ofs < cma_pkg::GPR_END;
  wire is_com = cur_ofs >= cma_pkg::GPR_END;
  wire mem_ok = is_gpr || is_com;
  logic [7:0] core_rd;
  always_comb begin
    case (cur_ofs)
      cma_pkg::OFS_PCL: core_rd = pc_reg[7:0];
      cma_pkg::OFS_STATUS: core_rd = {3'h0, status_reg};
      cma_pkg::OFS_P0L: core_rd = ptr_reg[0][7:0];
      cma_pkg::OFS_P0H: core_rd = ptr_reg[0][15:8];
      cma_pkg::OFS_P1L: core_rd = ptr_reg[1][7:0];
      cma_pkg::OFS_P1H: core_rd = ptr_reg[1][15:8];
      cma_pkg::OFS_BSR: core_rd = {3'h0, bsr_reg};
      cma_pkg::OFS_WREG: core_rd = w_reg;
      cma_pkg::OFS_PROGRAM_COUNTER_LATCH_HIGH: core_rd = {1'b0, program_counter_latch_high_reg};
      default: core_rd = 8'h00;
    endcase
  end
  wire dm_wr = (ind_wr && !prog_sel) || dw;
  wire dm_rd = (ind_rd && !prog_sel) || dir_rd;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic core_hit_reg;
  logic [7:0] core_rd_reg;
  logic mem_hit_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      core_hit_reg <= 1'b0;
      mem_hit_reg <= 1'b0;
      core_rd_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      core_hit_reg <= dm_rd && is_core;
      mem_hit_reg <= dm_rd && mem_ok;
      core_rd_reg <= core_rd;
      rvalid_reg <= dm_rd || (ind_rd && prog_sel && pend_reg);
    end
  end
  always_comb begin
    if (core_hit_reg) begin
      rdata_reg = core_rd_reg;
    end else if (mem_hit_reg) begin
      rdata_reg = ram_rdata;
    end else begin
      rdata_reg = 8'h00;
    end
  end
  // ****************
  // Outputs
  // ****************
  logic [11:0] ram_addr_reg;
  logic ram_wr_reg;
  logic ram_rd_reg;
  logic [7:0] ram_wdata_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ram_addr_reg <= 12'h000;
      ram_wr_reg <= 1'b0;
      ram_rd_reg <= 1'b0;
      ram_wdata_reg <= 8'h00;
    end else begin
      ram_addr_reg <= cur_addr;
      ram_wr_reg <= dm_wr && mem_ok;
      ram_rd_reg <= dm_rd && mem_ok;
      ram_wdata_reg <= ind_wr ? ind_wdata : dir_wdata;
    end
  end
  assign ram_addr = ram_addr_reg;
  assign ram_wr = ram_wr_reg;
  assign ram_rd = ram_rd_reg;
  assign ram_wdata = ram_wdata_reg;
  assign rdata = pend_q ? prog_byte_reg : rdata_reg;
  assign rdata_valid = rvalid_reg;
  assign pc_out = pc_reg;
  assign prog_addr = (ind_rd && prog_sel) ? ptr_pa_w : pc_reg;
  assign stack_overflow_flag = ovf_reg;
  assign stack_underflow_flag = unf_reg;
  assign soft_reset = srst_reg;
  assign high_endurance = prog_addr >= cma_pkg::HE_LO &&
                          prog_addr <= cma_pkg::HE_HI;
  assign bank_select_register = bsr_reg;
  assign wreg_out = w_reg;
  // Program byte held, the address bus has moved on by the answer cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      prog_byte_reg <= 8'h00;
    end else begin
      pend_q <= ind_rd && prog_sel && pend_reg;
      if (ind_rd && prog_sel && pend_reg) begin
        prog_byte_reg <= prog_rdata[7:0];
      end
    end
  end
  // ****************
  // Checks
  // ****************
  chk_reset_vector: assert property (@(posedge ref_clk)
    $fell(rst) |-> pc_reg == cma_pkg::RESET_VEC)
    else $error("pc not at reset vector");
  chk_int_vector: assert property (@(posedge ref_clk) disable iff (rst)
    irq_take && !stall |=> pc_reg == cma_pkg::INT_VEC)
    else $error("interrupt did not vector");
  chk_pc_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    pc_reg < 15'(PROG_WORDS))
    else $error("pc outside program memory");
  chk_prog_stall: assert property (@(posedge ref_clk) disable iff (rst)
    ind_rd && prog_sel && !pend_reg |=> pend_reg)
    else $error("missing extra cycle");
  chk_prog_nowrite: assert property (@(posedge ref_clk) disable iff (rst)
    ind_wr && prog_sel |=> !ram_wr)
    else $error("write reached memory");
  chk_ovf_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    stk_ovf && !stall |=> ovf_reg ##1 ovf_reg)
    else $error("overflow flag lost");
  chk_shadow_restore: assert property (@(posedge ref_clk) disable iff (rst)
    retfie && !stall && !irq_take |=> w_reg == $past(sh_w))
    else $error("shadow not restored");
  chk_bank_direct: assert property (@(posedge ref_clk) disable iff (rst)
    dir_rd && !ind_rd && !ind_wr |=> ram_addr[11:7] == $past(bsr_reg))
    else $error("wrong bank");
endmodule : cma_core

// ===== verif/cma_mem_model.sv
// Program flash and data RAM model facing the addressing core
module cma_mem_model (
  // Clock
  input wire logic ref_clk,
  // Program flash
  input wire logic [14:0] prog_addr,
  output logic [13:0] prog_rdata,
  // Data RAM
  input wire logic [11:0] ram_addr,
  input wire logic ram_wr,
  input wire logic ram_rd,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:4095];
  logic [7:0] last;
  logic [11:0] home;
  logic hole;
  logic [6:0] ofs;
  assign ofs = ram_addr[6:0];
  // Shared bytes of every bank land in bank 0
  assign home = (ofs >= 7'h70) ? {5'h00, ofs} : ram_addr;
  assign hole = ofs >= cma_pkg::CORE_END && ofs < cma_pkg::SFR_END;
  // Only ten address bits decode
  assign prog_rdata = {4'h0, prog_addr[9:0]} * 14'h00A5 + 14'h1234;
  // Answer stands while the read strobe stands
  // Released data lines show the inverse of the last answer
  assign ram_rdata = ram_rd ? (hole ? 8'h00 : mem[home]) : ~last;
  initial begin
    last = 8'h5A;
  end
  always @(posedge ref_clk) begin
    if (ram_wr)
      mem[home] <= ram_wdata;
    if (ram_rd)
      last <= ram_rdata;
  end
endmodule : cma_mem_model

// ===== verif/cpu_memory_addressing_tb.sv
// Self-checking bench for the memory addressing core
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin \
  mismatches++; $display("BAD %0t %s", $time, m); end end
module cpu_memory_addressing_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] IRQ = 5'h10, CAL = 5'h08, JMP = 5'h04;
  localparam logic [4:0] RET = 5'h02, RFI = 5'h01;
  logic ref_clk, rst, step, jump, call, ret, irq_take, retfie;
  logic stack_rst_en, dir_wr, dir_rd, ind_sel, ind_rd, ind_wr;
  logic [14:0] jump_addr, prog_addr, pc_out, a, t;
  logic [7:0] wreg_in, dir_wdata, ind_wdata, ram_rdata, ram_wdata, rdata;
  logic [7:0] wreg_out, d;
  logic [6:0] dir_ofs;
  logic [4:0] status_in, bank_select_register, bsr_m;
  logic [13:0] prog_rdata, w;
  logic [11:0] ram_addr;
  logic [15:0] p;
  logic ram_wr, ram_rd, rdata_valid, stall, ovf, unf, soft_reset, he;
  logic [14:0] stk [$];
  logic [14:0] bnd [4] = '{15'h037F, 15'h0380, 15'h03FF, 15'h0400};
  int mismatches, tests_run, sr_seen;
  cma_core i_dut (.ref_clk(ref_clk), .rst(rst), .step(step),
    .jump(jump), .jump_addr(jump_addr), .call(call), .ret(ret),
    .irq_take(irq_take), .retfie(retfie), .stack_rst_en(stack_rst_en),
    .wreg_in(wreg_in), .status_in(status_in), .dir_ofs(dir_ofs),
    .dir_wr(dir_wr), .dir_rd(dir_rd), .dir_wdata(dir_wdata),
    .ind_sel(ind_sel), .ind_rd(ind_rd), .ind_wr(ind_wr),
    .ind_wdata(ind_wdata), .prog_rdata(prog_rdata),
    .ram_rdata(ram_rdata), .prog_addr(prog_addr), .pc_out(pc_out),
    .ram_addr(ram_addr), .ram_wr(ram_wr), .ram_rd(ram_rd),
    .ram_wdata(ram_wdata), .rdata(rdata), .rdata_valid(rdata_valid),
    .stall(stall), .stack_overflow_flag(ovf),
    .stack_underflow_flag(unf), .soft_reset(soft_reset),
    .high_endurance(he), .bank_select_register(bank_select_register),
    .wreg_out(wreg_out));
  cma_mem_model i_mem (.ref_clk(ref_clk), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .ram_addr(ram_addr), .ram_wr(ram_wr),
    .ram_rd(ram_rd), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
  // **********************************************
  // Reference model and bus tasks
  // **********************************************
  function automatic logic [13:0] pw(input logic [14:0] x);
    return {4'h0, x[9:0]} * 14'h00A5 + 14'h1234;
  endfunction : pw
  function automatic logic [11:0] lin(input logic [15:0] x);
    return {5'((x - 16'h2000) / 80), 7'(32 + (x - 16'h2000) % 80)};
  endfunction : lin
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    stk.delete();
    bsr_m = 5'h00;
  endtask : do_reset
  task automatic getv(input logic [7:0] e);
    int n;
    n = 0;
    #1;
    while (rdata_valid !== 1'b1 && n < 5) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 5) begin
      mismatches++;
      tally_and_finish();
    end
    `CHK(rdata, e, "read data")
  endtask : getv
  task automatic ctl(input logic [4:0] v, input logic [14:0] x,
    input logic [15:0] e);
    @(posedge ref_clk);
    {irq_take, call, jump, ret, retfie} <= v;
    jump_addr <= x;
    @(posedge ref_clk);
    {irq_take, call, jump, ret, retfie} <= 5'h00;
    #1;
    if (!e[15]) `CHK(prog_addr, e[14:0], "pc target")
  endtask : ctl
  task automatic dwr(input logic [6:0] o, input logic [7:0] v);
    @(posedge ref_clk);
    dir_ofs <= o;
    dir_wdata <= v;
    dir_wr <= 1'b1;
    @(posedge ref_clk);
    dir_wr <= 1'b0;
    if (o == cma_pkg::OFS_BSR) bsr_m = v[4:0];
    #1;
    if (o >= cma_pkg::SFR_END)
      `CHK({ram_wr, ram_addr}, {1'b1, bsr_m, o}, "dir addr")
    if (o == cma_pkg::OFS_BSR)
      `CHK(bank_select_register, bsr_m, "bank")
  endtask : dwr
  task automatic drd(input logic [6:0] o, input logic [7:0] e);
    @(posedge ref_clk);
    dir_ofs <= o;
    dir_rd <= 1'b1;
    @(posedge ref_clk);
    dir_rd <= 1'b0;
    getv(e);
  endtask : drd
  task automatic iwr(input logic s, input logic [12:0] e);
    @(posedge ref_clk);
    ind_sel <= s;
    ind_wdata <= 8'($urandom);
    ind_wr <= 1'b1;
    @(posedge ref_clk);
    ind_wr <= 1'b0;
    #1;
    if (e[12]) `CHK({ram_wr, ram_addr}, e, "ind addr")
    else `CHK(ram_wr, 1'b0, "prog write")
  endtask : iwr
  // Holds the read across the stall cycle
  task automatic ird(input logic s, input logic pm, input logic [7:0] e);
    @(posedge ref_clk);
    ind_sel <= s;
    ind_rd <= 1'b1;
    #1;
    `CHK(stall, pm, "stall")
    @(posedge ref_clk);
    if (pm) begin
      #1;
      `CHK(stall, 1'b0, "stall end")
      @(posedge ref_clk);
    end
    ind_rd <= 1'b0;
    getv(e);
  endtask : ird
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (soft_reset === 1'b1) sr_seen++;
  // **********************************************
  // Scenarios
  // **********************************************
  initial begin
    {rst, step, jump, call, ret, irq_take, retfie} = 7'h40;
    {stack_rst_en, dir_wr, dir_rd, ind_sel, ind_rd, ind_wr} = 6'h00;
    jump_addr = 15'h0000;
    {wreg_in, dir_wdata, ind_wdata, dir_ofs, status_in} = 36'h0;
    {mismatches, tests_run, sr_seen} = 0;
    void'($urandom(34));
    do_reset();
    #1;
    `CHK(pc_out, cma_pkg::RESET_VEC, "reset pc")
    `CHK({ovf, unf}, 2'b00, "flags")
    for (int i = 0; i < 12; i++) begin
      a = (i < 4) ? bnd[i] : 15'($urandom);
      ctl(JMP, a, a & 15'h03FF);
      `CHK(pc_out[9:0], a[9:0], "pc")
      `CHK(he, a[9:0] >= 10'h380, "endurance")
    end
    t = 15'h0040;
    ctl(JMP, t, t);
    for (int i = 0; i < 17; i++) begin
      if (stk.size() < cma_pkg::STACK_DEPTH) stk.push_back(t + 1);
      a = 15'($urandom % 1023);
      ctl(CAL, a, a);
      t = a;
      @(posedge ref_clk);
      #1;
      `CHK(ovf, i == 16, "overflow")
    end
    `CHK(sr_seen, 0, "no soft reset")
    while (stk.size() > 0) ctl(RET, 0, stk.pop_back());
    `CHK(unf, 1'b0, "no underflow")
    stack_rst_en <= 1'b1;
    ctl(RET, 0, 16'h8000);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK({unf, sr_seen}, 33'h100000001, "underflow")
    stack_rst_en <= 1'b0;
    do_reset();
    #1;
    `CHK({ovf, unf, pc_out}, 17'h00000, "mid reset")
    dwr(cma_pkg::OFS_BSR, 8'h03);
    d = 8'($urandom);
    @(posedge ref_clk);
    wreg_in <= d;
    step <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ctl(IRQ, 0, cma_pkg::INT_VEC);
    dwr(cma_pkg::OFS_BSR, 8'h09);
    @(posedge ref_clk);
    wreg_in <= ~d;
    repeat (3) @(posedge ref_clk);
    ctl(RFI, 0, 16'h8000);
    `CHK({bank_select_register, wreg_out}, {5'h03, d}, "shadow")
    @(posedge ref_clk);
    step <= 1'b0;
    dwr(cma_pkg::OFS_BSR, 8'h02);
    dwr(7'h30, d);
    drd(7'h30, d);
    dwr(cma_pkg::OFS_BSR, 8'h1F);
    dwr(7'h6F, ~d);
    drd(7'h6F, ~d);
    dwr(7'h75, 8'h3C);
    dwr(cma_pkg::OFS_BSR, 8'h05);
    drd(7'h75, 8'h3C);
    drd(cma_pkg::OFS_BSR, 8'h05);
    drd(7'h10, 8'h00);
    dwr(cma_pkg::OFS_P1H, 8'h01);
    dwr(cma_pkg::OFS_P1L, 8'h30);
    ird(1'b1, 1'b0, d);
    for (int j = 0; j < 4; j++) begin
      p = (j == 0) ? 16'h204F : 16'h2000 + 16'($urandom % 2560);
      dwr(cma_pkg::OFS_P0H, p[15:8]);
      dwr(cma_pkg::OFS_P0L, p[7:0]);
      iwr(1'b0, {1'b1, lin(p)});
      ird(1'b0, 1'b0, ind_wdata);
      a = 15'($urandom);
      w = pw(a);
      dwr(cma_pkg::OFS_P1H, {1'b1, a[14:8]});
      dwr(cma_pkg::OFS_P1L, a[7:0]);
      ird(1'b1, 1'b1, w[7:0]);
      `CHK(wreg_out, w[7:0], "w low byte")
      iwr(1'b1, 13'h0000);
    end
    tally_and_finish();
  end
endmodule : cpu_memory_addressing_tb
